// ---- inc/cras_pkg.sv ----
// Constants and types for the configuration register access-attribute bank.
// Assumes a 32-bit configuration data path with byte enables and a core clock.
package cras_pkg;
  localparam int          ADDR_W           = 6;
  localparam int          DATA_W           = 32;
  localparam int          NUM_REGS         = 4;
  // Register indices (dword addresses)
  localparam logic [5:0]  IDX_CTRL         = 6'h00;
  localparam logic [5:0]  IDX_STATUS       = 6'h01;
  localparam logic [5:0]  IDX_ONCE         = 6'h02;
  localparam logic [5:0]  IDX_CONFIG_ADDR  = 6'h03;
  // Per-register attribute masks
  localparam logic [31:0] CTRL_RW_MASK     = 32'h0000_00ff;
  localparam logic [31:0] CTRL_LOCKED_MASK = 32'h0000_ff00;
  localparam int          CTRL_LOCK_BIT    = 31;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  localparam logic [31:0] CTRL_WARM_KEEP   = 32'h0000_000f;
  localparam logic [31:0] STATUS_RO_MASK   = 32'h0000_00ff;
  localparam logic [31:0] STATUS_WC_MASK   = 32'h00ff_0000;
  localparam logic [31:0] ONCE_MASK        = 32'h0000_ffff;
  localparam logic [31:0] ONCE_RESET       = 32'h0000_0000;
  localparam logic [31:0] CFGA_MASK        = 32'h80ff_fffc;
  localparam logic [31:0] CFGA_RESET       = 32'h0000_0000;
  localparam int          STRAP_W          = 2;
  localparam int          STRAP_POS        = 16;
  localparam logic [31:0] RSVD_VALUE       = 32'h0000_0000;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] index;
    logic [3:0]        byte_en;
    logic [DATA_W-1:0] wdata;
  } cras_req_type;

  typedef struct packed {
    logic              done;
    logic [DATA_W-1:0] rdata;
  } cras_rsp_type;
endpackage

// ---- src/cras_bank.sv ----
// Configuration register bank with read-only, read/write, lockable,
// write-one-to-clear and write-once fields, and reserved locations.
// Assumes requests are synchronous single-cycle strobes from the host decoder.
`timescale 1ns/100ps
// Summary of operation
// - Read-only fields ignore every write
// - Read/write fields store and return writes
// - Lockable fields freeze once lock bit set
// - Writing one clears bit, zero leaves it
// - Write-once bits accept only first write
// - Reserved locations still complete access
// - Reserved locations discard all writes
// - Reset loads minimal boot defaults
// - Some defaults come from strap pins
// - Byte, word, dword access; address dword only
// - Multi-byte fields are little-endian
// - Warm reset keeps designated bits
module cras_bank (
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_pwr_ok,
  input  wire logic [cras_pkg::STRAP_W-1:0] i_strap,
  input  wire logic [7:0]                   i_status_event,
  input  wire logic [7:0]                   i_status_live,
  input  wire cras_pkg::cras_req_type       i_req,
  output cras_pkg::cras_rsp_type            o_rsp,
  output logic [31:0]                       o_ctrl,
  output logic [31:0]                       o_once,
  output logic [31:0]                       o_cfg_addr
);
  // Register contents
  logic [31:0] ctrl;
  logic [31:0] status;
  logic [31:0] once;
  logic [15:0] once_done;
  logic [31:0] cfg_addr;

  // Request decode and masks
  logic [31:0] strap_default;
  logic [31:0] wmask;
  logic [31:0] wr_ones;
  logic [31:0] ctrl_lock_mask;
  logic [31:0] ctrl_write_mask;
  logic [31:0] ctrl_read_mask;
  logic [31:0] status_read_mask;
  logic [7:0]  status_clear;
  logic        wr_any;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_once;
  logic        wr_cfga;
  logic        full_reset;
  logic        cfga_dword;
  logic        ctrl_locked;

  // Read path
  logic [31:0] next_rdata;
  logic [31:0] rsp_rdata;
  logic        rsp_done;

  // Power-good low during reset means a full reset
  assign full_reset = !i_rst_n && !i_pwr_ok;

  // Byte lane n covers data bits 8n+7 down to 8n
  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign wmask[8*b+7:8*b] = {8{i_req.byte_en[b]}};
  end

  assign wr_ones = i_req.wdata & wmask;

  // Only the four mapped indices decode; other writes fall away
  assign wr_any = i_req.valid && i_req.write;
  assign wr_ctrl = wr_any && (i_req.index == cras_pkg::IDX_CTRL);
  assign wr_status = wr_any && (i_req.index == cras_pkg::IDX_STATUS);
  assign wr_once = wr_any && (i_req.index == cras_pkg::IDX_ONCE);
  assign cfga_dword = (i_req.byte_en == 4'hf);
  assign wr_cfga = wr_any && (i_req.index == cras_pkg::IDX_CONFIG_ADDR) && cfga_dword;

  // Strap level becomes the status default
  assign strap_default = 32'(i_strap) << cras_pkg::STRAP_POS;

  // Lockable byte and lock bit leave the write mask once locked
  assign ctrl_locked = ctrl[cras_pkg::CTRL_LOCK_BIT];
  assign ctrl_lock_mask = 32'h0000_0001 << cras_pkg::CTRL_LOCK_BIT;
  assign ctrl_write_mask = cras_pkg::CTRL_RW_MASK
                           | (ctrl_locked ? 32'h0000_0000 : (cras_pkg::CTRL_LOCKED_MASK | ctrl_lock_mask));
  assign ctrl_read_mask = cras_pkg::CTRL_RW_MASK | cras_pkg::CTRL_LOCKED_MASK | ctrl_lock_mask;
  assign status_read_mask = cras_pkg::STATUS_RO_MASK | cras_pkg::STATUS_WC_MASK;
  // Ones written to the sticky byte clear it
  assign status_clear = wr_status ? wr_ones[23:16] : 8'h00;

  // Control register
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      if (full_reset)
      begin
        ctrl <= cras_pkg::CTRL_RESET;
      end
      else
      begin
        ctrl <= (ctrl & cras_pkg::CTRL_WARM_KEEP) | (cras_pkg::CTRL_RESET & ~cras_pkg::CTRL_WARM_KEEP);
      end
    end
    else if (wr_ctrl)
    begin
      ctrl <= (ctrl & ~(wmask & ctrl_write_mask)) | (wr_ones & ctrl_write_mask);
    end
  end

  // Status: live read-only byte, sticky event byte, reserved bytes
  // Event set wins over a clear in the same cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      status <= strap_default;
    end
    else
    begin
      status[7:0] <= i_status_live;
      status[15:8] <= 8'h00;
      status[23:16] <= i_status_event | (status[23:16] & ~status_clear);
      status[31:24] <= 8'h00;
    end
  end

  // Write-once bits; done flags cleared only by a full reset
  always_ff @(posedge i_clk_sys)
  begin
    if (full_reset)
    begin
      once <= cras_pkg::ONCE_RESET;
      once_done <= 16'h0000;
    end
    else if (i_rst_n && wr_once)
    begin
      for (int i = 0; i < 16; i++)
      begin
        if (wmask[i] && !once_done[i])
        begin
          once[i] <= i_req.wdata[i];
          once_done[i] <= 1'b1;
        end
      end
    end
  end

  // Configuration address, taken only as a whole dword
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      cfg_addr <= cras_pkg::CFGA_RESET;
    end
    else if (wr_cfga)
    begin
      cfg_addr <= i_req.wdata & cras_pkg::CFGA_MASK;
    end
  end

  // Read decode; reserved bits and locations answer a constant
  always_comb
  begin
    next_rdata = cras_pkg::RSVD_VALUE;
    if (i_req.index == cras_pkg::IDX_CTRL)
    begin
      next_rdata = ctrl & ctrl_read_mask;
    end
    else if (i_req.index == cras_pkg::IDX_STATUS)
    begin
      next_rdata = status & status_read_mask;
    end
    else if (i_req.index == cras_pkg::IDX_ONCE)
    begin
      next_rdata = once & cras_pkg::ONCE_MASK;
    end
    else if (i_req.index == cras_pkg::IDX_CONFIG_ADDR)
    begin
      if (cfga_dword)
      begin
        next_rdata = cfg_addr;
      end
    end
    else
    begin
      next_rdata = cras_pkg::RSVD_VALUE;
    end
  end

  // Completion for every index, mapped or not
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      rsp_done <= 1'b0;
    end
    else
    begin
      rsp_done <= i_req.valid;
    end
  end

  // Read data register
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      rsp_rdata <= cras_pkg::RSVD_VALUE;
    end
    else
    begin
      rsp_rdata <= next_rdata;
    end
  end

  // Outputs
  assign o_rsp = {rsp_done, rsp_rdata};
  assign o_ctrl = ctrl;
  assign o_once = once;
  assign o_cfg_addr = cfg_addr;
endmodule

// ---- verif/cras_props.sv ----
// Port assertions for the register bank.
// Bound to every cras_bank instance.
`timescale 1ns/100ps
module cras_props (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst_n,
  input wire cras_pkg::cras_req_type i_req,
  input wire cras_pkg::cras_rsp_type o_rsp,
  input wire logic [31:0]            o_ctrl,
  input wire logic [31:0]            o_once,
  input wire logic [31:0]            o_cfg_addr
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire       w = i_req.valid && i_req.write;
  wire [5:0] x = i_req.index;
  property p_done; i_req.valid |=> o_rsp.done; endproperty
  a_done: assert property (p_done) else $error("no answer");
  property p_idle; !i_req.valid |=> !o_rsp.done; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_rw; w && x == 0 && i_req.byte_en[0] |=> o_ctrl[7:0] == $past(i_req.wdata[7:0]); endproperty
  a_rw: assert property (p_rw) else $error("ctrl byte lost");
  property p_lock; w && x == 0 && o_ctrl[31] |=> $stable(o_ctrl[31:8]); endproperty
  a_lock: assert property (p_lock) else $error("locked field moved");
  property p_once; o_once != 0 |=> (o_once & $past(o_once)) == $past(o_once); endproperty
  a_once: assert property (p_once) else $error("once bit changed");
  property p_cfgp; w && x == 3 && i_req.byte_en != 4'hf |=> $stable(o_cfg_addr); endproperty
  a_cfgp: assert property (p_cfgp) else $error("partial address write taken");
  property p_cfgw; w && x == 3 && i_req.byte_en == 4'hf |=> o_cfg_addr == ($past(i_req.wdata) & 32'h80ff_fffc);
  endproperty
  a_cfgw: assert property (p_cfgw) else $error("address write lost");
  property p_rsvd; w && x > 3 |=> $stable({o_ctrl, o_once, o_cfg_addr}); endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved write took effect");
  c_lock: cover property (w && x == 0 && o_ctrl[31]);
  c_once: cover property (w && x == 2 && o_once != 0);
  c_rsvd: cover property (w && x > 3);
endmodule
bind cras_bank cras_props u_props (
  .i_clk_sys  (i_clk_sys),
  .i_rst_n    (i_rst_n),
  .i_req      (i_req),
  .o_rsp      (o_rsp),
  .o_ctrl     (o_ctrl),
  .o_once     (o_once),
  .o_cfg_addr (o_cfg_addr)
);

// ---- verif/cras_host.sv ----
// Host software model making configuration accesses.
// Assumes one access at a time, driven at falling edges.
`timescale 1ns/100ps
module cras_host (
  input  wire logic                   i_clk_sys,
  input  wire cras_pkg::cras_rsp_type i_rsp,
  output cras_pkg::cras_req_type      o_req
);
  logic        done;
  logic [31:0] rd;
  initial o_req = '0;
  // One access; answer taken a cycle later
  task acc(input logic w, input logic [5:0] x, input logic [3:0] be, input logic [31:0] d);
    @(negedge i_clk_sys) o_req = {1'b1, w, x, be, d};
    @(negedge i_clk_sys) o_req = '0;
    done = i_rsp.done;
    rd = i_rsp.rdata;
  endtask
endmodule

// ---- verif/testbench.sv ----
// Bench for the register bank; host model makes accesses.
// Inputs change at falling edges.
`timescale 1ns/100ps
module testbench;
  logic i_clk_sys = 0, i_rst_n = 0, i_pwr_ok = 0;
  logic [7:0] ev = 0, live = 0;
  logic [1:0] strap = 2'h2;
  int n_errors = 0, compares = 0, cyc = 0;
  cras_pkg::cras_req_type req;
  cras_pkg::cras_rsp_type rsp;
  logic [31:0] ctrl, once, cfg;
  always #50 i_clk_sys = ~i_clk_sys;
  cras_host u_host (.i_clk_sys(i_clk_sys), .i_rsp(rsp), .o_req(req));
  cras_bank dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_pwr_ok(i_pwr_ok), .i_strap(strap),
    .i_status_event(ev), .i_status_live(live), .i_req(req), .o_rsp(rsp), .o_ctrl(ctrl), .o_once(once),
    .o_cfg_addr(cfg));
  task chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task print_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task rst(input logic pw);
    {i_rst_n, i_pwr_ok} = {1'b0, pw};
    repeat (5) @(negedge i_clk_sys);
    {i_rst_n, i_pwr_ok} = 2'h3;
  endtask
  task t_dflt;
    chk("dflt", ctrl | once | cfg, 0);
    u_host.acc(0, 1, 4'hf, 0);
    chk("strap", u_host.rd & 32'h0003_0000, 32'h0002_0000);
  endtask
  task t_ctrl;
    u_host.acc(1, 0, 4'h1, 32'ha5);
    u_host.acc(1, 0, 4'h2, 32'h3c00);
    u_host.acc(0, 0, 4'hf, 0);
    chk("ctrl", u_host.rd, 32'h3ca5);
    u_host.acc(1, 0, 4'hf, (u_host.rd & 32'hffff_ff00) | 32'h5a);
    u_host.acc(0, 0, 4'hf, 0);
    chk("merge", u_host.rd & 32'h0000_ffff, 32'h3c5a);
    u_host.acc(1, 0, 4'h8, 32'h8000_0000);
    u_host.acc(1, 0, 4'hf, 32'hff11);
    chk("lock", ctrl, 32'h8000_3c11);
  endtask
  task t_status;
    u_host.acc(1, 1, 4'hf, 32'h00ff_0000);
    @(negedge i_clk_sys) ev = 8'h81;
    @(negedge i_clk_sys) ev = 0;
    live = 8'hc3;
    u_host.acc(1, 1, 4'hf, 32'h0001_00ff);
    u_host.acc(0, 1, 4'hf, 0);
    chk("status", u_host.rd & 32'h00ff_0000, 32'h0080_0000);
    chk("live", u_host.rd & 32'hff, 32'hc3);
  endtask
  task t_once;
    u_host.acc(1, 2, 4'h3, 32'h1234);
    u_host.acc(1, 2, 4'hf, 32'hffff);
    chk("once1", once, 32'h1234);
    strap = 2'h1;
    rst(1);
    u_host.acc(1, 2, 4'hf, 0);
    chk("once", once, 32'h1234);
    chk("warm", ctrl, 32'h1);
    u_host.acc(0, 1, 4'hf, 0);
    chk("wstat", u_host.rd & 32'h00ff_0000, 32'h0001_0000);
    rst(0);
    chk("full", ctrl | once, 0);
    u_host.acc(1, 2, 4'h1, 32'hab);
    chk("reopen", once, 32'hab);
  endtask
  task t_rsvd;
    u_host.acc(1, 3, 4'hf, '1);
    u_host.acc(1, 3, 4'h1, 0);
    chk("cfg", cfg, 32'h80ff_fffc);
    u_host.acc(1, 6'h3f, 4'hf, '1);
    chk("done", u_host.done, 1);
    u_host.acc(0, 6'h3f, 4'hf, 0);
    chk("rsvd", u_host.rd, 0);
  endtask
  initial
  begin
    rst(0);
    t_dflt;
    t_ctrl;
    t_status;
    t_once;
    t_rsvd;
    print_verdict;
  end
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 500)
    begin
      n_errors++;
      print_verdict;
    end
  end
endmodule
